/* File: verilog/spp_regs.vh */
// Purpose: Shared constants of the serial position port.
// Assumes: Included by bare name from the design files.
// Notes: Holds codes, status values and timing counts only.
`ifndef SPP_REGS_VH
`define SPP_REGS_VH

// Status byte values for register accesses to configuration memory.
`define SPP_STAT_BUSY 8'h02
`define SPP_STAT_DONE 8'h00

// Port A protocol select codes.
`define SPP_MODE_SPI0 3'h0
`define SPP_MODE_SPI1 3'h1
`define SPP_MODE_SSI2 3'h2
`define SPP_MODE_SSI 3'h4
`define SPP_MODE_ERRL 3'h5
`define SPP_MODE_ERRH 3'h6
`define SPP_MODE_EXT 3'h7

// Clock period and SSI timeout, both in ns; the count rounds up.
`define SPP_MCLK_NS 50
`define SPP_TOUT_NS 20000
`define SPP_TOUT_CYC ((`SPP_TOUT_NS + `SPP_MCLK_NS - 1) / `SPP_MCLK_NS)

`endif

/* File: verilog/spp_fifo.v */
// Purpose: Position word buffer between the sampler and the SSI shifter.
// Assumes: One clock, synchronous active high reset.
// Notes: Ready and valid flags are registered, updated with the count.
`timescale 1ns/1ps
module spp_fifo #(
    parameter WIDTH = 17,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire mclk, // System clock.
    input wire reset, // Synchronous reset, active high.
    input wire [WIDTH-1:0] in_data, // Word to store.
    input wire in_valid, // Source offers a word.
    output reg in_ready, // Space is free.
    output wire [WIDTH-1:0] out_data, // Oldest word.
    output reg out_valid, // A word is held.
    input wire out_ready // Sink takes the oldest word.
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;
    reg [AW:0] next_count;

    assign do_wr = in_valid & in_ready;
    assign do_rd = out_ready & out_valid;
    assign out_data = mem[rd_ptr];

    // Count follows both sides; a write and a read together cancel.
    always @* begin
        next_count = count;
        if (do_wr & ~do_rd) begin
            next_count = count + {{AW{1'b0}}, 1'b1};
        end else if (do_rd & ~do_wr) begin
            next_count = count - {{AW{1'b0}}, 1'b1};
        end
    end

    // Pointers wrap at the depth so any depth works, not only powers of 2.
    always @(posedge mclk) begin
        if (reset) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (do_wr) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} :
                          wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} :
                          rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            count <= next_count;
            in_ready <= (next_count != DEPTH);
            out_valid <= (next_count != {(AW+1){1'b0}});
        end
    end
endmodule

/* File: verilog/spp_port.v */
// Purpose: Serial position port, SPI memory status and SSI word shifter.
// Assumes: The master clock pin is slow against mclk (400 ns period).
// Notes: Frame timing is rebuilt from sampled edges of the master clock.
`timescale 1ns/1ps
`include "spp_regs.vh"
module spp_port #(
    parameter POS_W = 16,
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3,
    parameter TOUT_CYC = `SPP_TOUT_CYC
) (
    input wire mclk, // System clock, 20 MHz.
    input wire reset, // Synchronous reset, active high.
    input wire [2:0] port_a_protocol_select, // Port A protocol code.
    input wire gray_code_select, // Gray coded SSI output.
    input wire trailing_zero, // Append a zero after the data.
    input wire ssi_clock, // Master shift clock pin, idle high.
    output reg serial_data_output, // Serial data pin, idle high.
    input wire [POS_W-1:0] pos_data, // Position sample.
    input wire pos_error, // Error state of that sample.
    input wire pos_valid, // Sample offered.
    output wire pos_ready, // Buffer can take a sample.
    input wire mem_cmd_start, // Single register command to memory.
    input wire mem_xfer_done, // Memory transfer finished, pulse.
    input wire mem_xfer_err, // That transfer failed.
    input wire [1:0] reg_valid_fail, // Valid and fail of other commands.
    output reg [7:0] status_data, // Status/data byte.
    output reg [7:0] spi_status, // SPI status byte.
    output reg [1:0] valid_fail, // Valid and fail bits as reported.
    output reg memory_error_flag, // Status register one memory error.
    input wire large_period_system, // 512 or 1024 master periods.
    input wire absolute_position_reset_command, // Command pulse.
    output reg startup_complete // Start-up sequence finished.
);
    localparam SH_W = POS_W + 2;
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SHIFT = 3'b010;
    localparam [2:0] ST_TOUT = 3'b100;

    reg [2:0] state;
    reg clk_s1;
    reg clk_s2;
    reg clk_s3;
    reg clk_stable;
    reg clk_fall;
    reg clk_rise;
    reg [SH_W-1:0] shreg;
    reg [5:0] bits_left;
    reg [15:0] tout_cnt;
    reg first_word;
    reg mem_busy;
    reg [SH_W-1:0] next_load;
    reg [5:0] next_bits;
    reg [POS_W:0] whole;
    reg [POS_W-1:0] gpos;
    reg err_bit;
    wire [POS_W:0] fifo_out;
    wire fifo_valid;
    wire fifo_take;
    wire ssi_mode;
    wire err_mode;
    wire spi_mode;

    assign spi_mode = (port_a_protocol_select == `SPP_MODE_SPI0) ||
                      (port_a_protocol_select == `SPP_MODE_SPI1);
    assign ssi_mode = (port_a_protocol_select == `SPP_MODE_SSI2) ||
                      (port_a_protocol_select == `SPP_MODE_SSI) ||
                      err_mode ||
                      (port_a_protocol_select == `SPP_MODE_EXT);
    assign err_mode = (port_a_protocol_select == `SPP_MODE_ERRL) ||
                      (port_a_protocol_select == `SPP_MODE_ERRH);
    // A word leaves the buffer at the latching edge of a frame.
    assign fifo_take = ssi_mode & (state == ST_IDLE) & clk_fall;

    spp_fifo #(
        .WIDTH(POS_W + 1),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .mclk(mclk),
        .reset(reset),
        .in_data({pos_data, pos_error}),
        .in_valid(pos_valid),
        .in_ready(pos_ready),
        .out_data(fifo_out),
        .out_valid(fifo_valid),
        .out_ready(fifo_take)
    );

    // Three stage sampler; a level counts only once stages two and three
    // agree, so a single glitchy sample never makes an edge.
    always @(posedge mclk) begin
        if (reset) begin
            clk_s1 <= 1'b1;
            clk_s2 <= 1'b1;
            clk_s3 <= 1'b1;
            clk_stable <= 1'b1;
            clk_fall <= 1'b0;
            clk_rise <= 1'b0;
        end else begin
            clk_s1 <= ssi_clock;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            clk_fall <= 1'b0;
            clk_rise <= 1'b0;
            if ((clk_s2 == clk_s3) && (clk_s3 != clk_stable)) begin
                clk_stable <= clk_s3;
                clk_fall <= ~clk_s3;
                clk_rise <= clk_s3;
            end
        end
    end

    // Word build: error bit polarity by mode, then Gray coding.
    // An empty buffer yields a zero word with the error state set.
    always @* begin
        err_bit = fifo_valid ? fifo_out[0] : 1'b1;
        if (port_a_protocol_select == `SPP_MODE_ERRL) begin
            err_bit = ~err_bit;
        end
        gpos = fifo_valid ? fifo_out[POS_W:1] : {POS_W{1'b0}};
        whole = {gpos, err_bit};
        if (gray_code_select) begin
            gpos = gpos ^ (gpos >> 1);
        end
        if (err_mode) begin
            // Without the trailing zero the coder runs over the error bit
            // too, so the error bit comes out XORed with the position LSB.
            if (gray_code_select & ~trailing_zero) begin
                whole = whole ^ (whole >> 1);
            end else begin
                whole = {gpos, err_bit};
            end
            next_load = {whole, 1'b0};
            next_bits = POS_W[5:0] + 6'h01 + {5'h00, trailing_zero};
        end else begin
            next_load = {gpos, 2'b00};
            next_bits = POS_W[5:0] + {5'h00, trailing_zero};
        end
        // First frame after reset is one bit late; the init pulse frame
        // of the master absorbs it.
        if (first_word) begin
            next_load = {1'b0, next_load[SH_W-1:1]};
        end
    end

    // SSI frame: falling edge latches, each rising edge puts out a bit,
    // the line holds its last level until the timeout ends.
    always @(posedge mclk) begin
        if (reset) begin
            state <= ST_IDLE;
            shreg <= {SH_W{1'b0}};
            bits_left <= 6'h00;
            tout_cnt <= 16'h0000;
            first_word <= 1'b1;
            serial_data_output <= 1'b1;
        end else begin
            case (state)
                ST_IDLE: begin
                    serial_data_output <= 1'b1;
                    if (fifo_take) begin
                        shreg <= next_load;
                        bits_left <= next_bits;
                        tout_cnt <= TOUT_CYC[15:0];
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (clk_rise) begin
                        tout_cnt <= TOUT_CYC[15:0];
                        if (bits_left != 6'h00) begin
                            serial_data_output <= shreg[SH_W-1];
                            shreg <= {shreg[SH_W-2:0], 1'b0};
                            bits_left <= bits_left - 6'h01;
                        end
                    end else if (clk_fall) begin
                        tout_cnt <= TOUT_CYC[15:0];
                    end else if (tout_cnt == 16'h0001) begin
                        state <= ST_TOUT;
                    end else begin
                        tout_cnt <= tout_cnt - 16'h0001;
                    end
                end
                ST_TOUT: begin
                    // The misalignment lasts for one frame only.
                    first_word <= 1'b0;
                    serial_data_output <= 1'b1;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Memory access status: busy code until the transfer ends; a new
    // start in the same cycle as a finish wins, so busy is never lost.
    always @(posedge mclk) begin
        if (reset) begin
            mem_busy <= 1'b0;
            status_data <= `SPP_STAT_DONE;
            spi_status <= `SPP_STAT_DONE;
            memory_error_flag <= 1'b0;
            valid_fail <= 2'b00;
        end else begin
            if (spi_mode & mem_cmd_start) begin
                mem_busy <= 1'b1;
                status_data <= `SPP_STAT_BUSY;
                spi_status <= `SPP_STAT_BUSY;
            end else if (mem_busy & mem_xfer_done) begin
                mem_busy <= 1'b0;
                status_data <= `SPP_STAT_DONE;
                spi_status <= `SPP_STAT_DONE;
            end
            if (mem_busy & mem_xfer_done) begin
                memory_error_flag <= mem_xfer_err;
            end
            // Valid and fail carry nothing for memory accesses, so they
            // read as zero then rather than stale values.
            if (mem_busy | (spi_mode & mem_cmd_start)) begin
                valid_fail <= 2'b00;
            end else begin
                valid_fail <= reg_valid_fail;
            end
        end
    end

    // Long period systems finish start-up only on the reset command.
    always @(posedge mclk) begin
        if (reset) begin
            startup_complete <= 1'b0;
        end else if (~large_period_system) begin
            startup_complete <= 1'b1;
        end else if (absolute_position_reset_command) begin
            startup_complete <= 1'b1;
        end
    end
endmodule

/* File: sim/spp_port_checker.sv */
// Purpose: Temporal checks on the serial position port outputs.
// Assumes: Bound to spp_port and sees its ports only.
// Notes: The idle check relies on the shift clock parked high.
`timescale 1ns/1ps
module spp_port_checker #(
    parameter TOUT_CYC = 400
) (
    input logic mclk, // Clock.
    input logic reset, // Sync reset.
    input logic [2:0] port_a_protocol_select, // Protocol.
    input logic ssi_clock, // Shift clock.
    input logic serial_data_output, // Serial data.
    input logic mem_cmd_start, // Memory command.
    input logic mem_xfer_done, // Transfer done.
    input logic mem_xfer_err, // Transfer failed.
    input logic [7:0] status_data, // Status byte.
    input logic [7:0] spi_status, // SPI status.
    input logic [1:0] valid_fail, // Valid, fail.
    input logic memory_error_flag // Memory error.
);
    logic ssi_q;
    logic [9:0] quiet;
    // Quiet cycles of the shift clock; saturates so it never wraps.
    always_ff @(posedge mclk) begin
        ssi_q <= ssi_clock;
        if (reset || ssi_clock != ssi_q) begin
            quiet <= 10'h000;
        end else if (quiet != 10'h3FF) begin
            quiet <= quiet + 10'h001;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_start;
        mem_cmd_start && port_a_protocol_select < 3'h2;
    endsequence
    sequence s_busy;
        status_data == 8'h02 && spi_status == 8'h02;
    endsequence
    sequence s_end;
        s_busy ##0 (mem_xfer_done && !mem_cmd_start);
    endsequence
    property p_busy; s_start |=> s_busy; endproperty
    property p_hold; s_busy ##0 !mem_xfer_done |=> s_busy; endproperty
    property p_done;
        s_end |=> status_data == 8'h00 && spi_status == 8'h00;
    endproperty
    property p_err;
        s_end |=> memory_error_flag == $past(mem_xfer_err);
    endproperty
    property p_flag;
        $changed(memory_error_flag) |-> $past(mem_xfer_done);
    endproperty
    property p_vf; s_busy |-> valid_fail == 2'b00; endproperty
    property p_ign;
        mem_cmd_start && port_a_protocol_select > 3'h1
            && status_data == 8'h00 |=> status_data == 8'h00;
    endproperty
    property p_idle;
        ssi_clock && quiet == TOUT_CYC + 12 |-> serial_data_output;
    endproperty
    a_busy: assert property (p_busy) else $error("no busy");
    a_hold: assert property (p_hold) else $error("busy lost");
    a_done: assert property (p_done) else $error("no done");
    a_err: assert property (p_err) else $error("bad flag");
    a_flag: assert property (p_flag) else $error("flag moved");
    a_vf: assert property (p_vf) else $error("valid set");
    a_ign: assert property (p_ign) else $error("ssi start");
    a_idle: assert property (p_idle) else $error("not idle");
endmodule

bind spp_port spp_port_checker #(.TOUT_CYC(TOUT_CYC)) i_chk (
    .mclk(mclk), .reset(reset), .ssi_clock(ssi_clock),
    .port_a_protocol_select(port_a_protocol_select),
    .serial_data_output(serial_data_output),
    .mem_cmd_start(mem_cmd_start), .mem_xfer_done(mem_xfer_done),
    .mem_xfer_err(mem_xfer_err), .status_data(status_data),
    .spi_status(spi_status), .valid_fail(valid_fail),
    .memory_error_flag(memory_error_flag));

/* File: sim/spp_master.sv */
// Purpose: Behavioural serial master that clocks out position frames.
// Assumes: The device drives each bit a few cycles after a rise.
// Notes: Short low, long high phase, so bits settle before sampling.
`timescale 1ns/1ps
module spp_master (
    output logic ssi_clock, // Shift clock, idle high.
    input logic serial_data_output // Data from the device.
);
    initial ssi_clock = 1'b1;
    // Any pulse count, so extra zero pulses and a lone init pulse
    // come from here; the clock stands high between frames.
    task automatic read_frame(input int n, output logic [17:0] v);
        v = 18'h00000;
        #13;
        for (int i = 0; i < n; i++) begin
            ssi_clock = 1'b0;
            #100;
            ssi_clock = 1'b1;
            #295;
            v = {v[16:0], serial_data_output};
            #5;
        end
    endtask
endmodule

/* File: sim/tb.sv */
// Purpose: Self-checking bench of the serial position port.
// Assumes: spp_master clocks frames; timeout cut to 20 cycles.
// Notes: Rows are read back after filling the buffer to refusal.
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0, rst = 1'b1, gray = 1'b0, tz = 1'b0, pv = 1'b0;
    logic pe = 1'b0, go = 1'b0, dn = 1'b0, xe = 1'b0, lg = 1'b1, ar = 1'b0;
    logic [2:0] sel = 3'h4;
    logic [15:0] pd = 16'h0000;
    logic sck, sdo, prdy, mflag, sup;
    logic [7:0] sdat, sst;
    logic [1:0] vf;
    logic [17:0] word, want;
    int n_fail = 0, n_compared = 0, nb;
    // Rows: mode, gray and trailing zero, position, error.
    logic [21:0] rows [8] = '{{3'h4, 2'h0, 16'hA5C3, 1'b0},
        {3'h4, 2'h3, 16'h8001, 1'b0}, {3'h5, 2'h3, 16'h1234, 1'b1},
        {3'h5, 2'h3, 16'hFFFF, 1'b0}, {3'h6, 2'h3, 16'h00F0, 1'b1},
        {3'h6, 2'h0, 16'h7E81, 1'b0}, {3'h7, 2'h1, 16'hC00C, 1'b0},
        {3'h2, 2'h0, 16'h0F0F, 1'b0}};
    // Clock, design and far-side master.
    always #25 mclk = ~mclk;
    spp_port #(.TOUT_CYC(20)) i_dut (.mclk(mclk), .reset(rst),
        .port_a_protocol_select(sel), .gray_code_select(gray),
        .trailing_zero(tz), .ssi_clock(sck), .serial_data_output(sdo),
        .pos_data(pd), .pos_error(pe), .pos_valid(pv), .pos_ready(prdy),
        .mem_cmd_start(go), .mem_xfer_done(dn), .mem_xfer_err(xe),
        .reg_valid_fail(2'b11), .status_data(sdat), .spi_status(sst),
        .valid_fail(vf), .memory_error_flag(mflag),
        .large_period_system(lg), .absolute_position_reset_command(ar),
        .startup_complete(sup));
    spp_master i_mst (.ssi_clock(sck), .serial_data_output(sdo));
    // Sample at the falling edge so all rising-edge updates have landed.
    task settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    task check(input string what, input logic [17:0] seen, want);
        n_compared++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask
    task wrap_up;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Frame bits, MSB first: data, error bit, then trailing zero.
    function automatic logic [17:0] frame(input logic [21:0] r,
                                          output int n);
        logic [17:0] v;
        v = {2'b00, r[18] ? r[16:1] ^ (r[16:1] >> 1) : r[16:1]};
        n = 16;
        if (r[21:19] == 3'h5 || r[21:19] == 3'h6) begin
            v = {v[16:0], r[0] ^ (r[21:19] == 3'h5)};
            n++;
        end
        if (r[17]) begin
            v = {v[16:0], 1'b0};
            n++;
        end
        return v;
    endfunction
    // Main sequence: start-up, memory status, then the SSI cases.
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        settle(3);
        check("idle line", sdo, 1'b1);
        check("startup", sup, 1'b0);
        check("status", sdat, 8'h00);
        check("ready", prdy, 1'b1);
        @(posedge mclk);
        ar <= 1'b1;
        @(posedge mclk);
        ar <= 1'b0;
        settle(1);
        check("startup", sup, 1'b1);
        for (int m = 0; m < 3; m++) begin
            @(posedge mclk);
            sel <= (m == 2) ? 3'h4 : m[2:0];
            go <= 1'b1;
            @(posedge mclk);
            go <= 1'b0;
            settle(0);
            check("status", sdat, (m == 2) ? 8'h00 : 8'h02);
            check("spi status", sst, (m == 2) ? 8'h00 : 8'h02);
            check("valid fail", vf, (m == 2) ? 2'b11 : 2'b00);
            @(posedge mclk);
            dn <= (m != 2);
            xe <= (m == 0);
            @(posedge mclk);
            dn <= 1'b0;
            settle(1);
            check("status", sdat, 8'h00);
            check("spi status", sst, 8'h00);
            check("mem flag", mflag, m == 0);
        end
        @(posedge mclk);
        pd <= 16'hB00D;
        pv <= 1'b1;
        @(posedge mclk);
        pv <= 1'b0;
        settle(2);
        i_mst.read_frame(16, word);
        check("first word", word, 18'h05806);
        settle(80);
        @(posedge mclk);
        rst <= 1'b1;
        lg <= 1'b0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        settle(1);
        check("startup", sup, 1'b1);
        i_mst.read_frame(1, word);
        settle(80);
        for (int i = 0; i < 9; i++) begin
            @(posedge mclk);
            pd <= rows[i % 8][16:1];
            pe <= rows[i % 8][0];
            pv <= 1'b1;
        end
        @(posedge mclk);
        pv <= 1'b0;
        settle(0);
        check("ready when full", prdy, 1'b0);
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            sel <= rows[i][21:19];
            gray <= rows[i][18];
            tz <= rows[i][17];
            want = frame(rows[i], nb);
            settle(1);
            i_mst.read_frame(nb, word);
            check("frame", word, want);
            settle(80);
        end
        // Error-bit Gray mode without the trailing zero codes the error
        // bit with the position; an odd position shows the wrong code.
        @(posedge mclk);
        sel <= 3'h6;
        gray <= 1'b1;
        tz <= 1'b0;
        pd <= 16'h1235;
        pe <= 1'b0;
        pv <= 1'b1;
        @(posedge mclk);
        pv <= 1'b0;
        settle(2);
        i_mst.read_frame(17, word);
        check("whole gray", word, 18'h0365F);
        settle(80);
        // An empty buffer gives a zero position with the error bit set.
        @(posedge mclk);
        gray <= 1'b0;
        settle(1);
        i_mst.read_frame(17, word);
        check("empty word", word, 18'h00001);
        settle(80);
        check("ready when empty", prdy, 1'b1);
        wrap_up;
    end
endmodule
